/* design/clpl_top.sv */
// chain link control, pen hit latch and ahb-lite register slave
//
// Local design decisions: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "clpl_defines.svh"

module clpl_top
  import clpl_pkg::*;
(
  input wire logic hclk, // system clock, 50 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic [31:0] hrdata, // read data
  output logic hresp, // always okay
  input wire logic pen_light_pulse_n, // pen light pulse
  input wire logic pen_button_n, // pen button level
  input wire logic ext_trig_n, // external trigger input
  input wire logic ring_rx_pin, // ring receive pin
  output logic ring_tx_pin, // ring transmit pin
  input wire logic local_tx, // local serial transmitter
  output logic local_rx, // received data to local uart
  output logic rts_n, // request to send
  input wire logic pen_hit_n_in, // shared hit line level
  output logic pen_hit_n_out, // shared hit line drive value
  output logic pen_hit_n_oe, // shared hit line pull low
  input wire logic pen_hit_clear_in, // shared clear line level
  output logic pen_hit_clear_out, // shared clear drive value
  output logic pen_hit_clear_oe, // shared clear pull
  input wire logic trig_n_in, // shared trigger line level
  output logic trig_n_out, // shared trigger drive value
  output logic trig_n_oe, // shared trigger pull low
  input wire logic all_units_ready_in, // all-ready line level
  output logic all_units_ready_out, // all-ready drive value
  output logic all_units_ready_oe, // all-ready pull low
  output logic pen_hit_flag_n, // hit flag to cpu
  output logic pen_button_irq, // button interrupt pulse
  output logic trigger_irq, // trigger interrupt pulse
  output logic unit_reset_req, // follower reset pulse
  output logic refresh_en // display refresh running
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [`CLPL_SY_N-1:0] sy_raw;
  logic [`CLPL_SY_N-1:0] sy_meta_reg;
  logic [`CLPL_SY_N-1:0] sy_reg;
  logic [`CLPL_SY_N-1:0] sy_prev_reg;

  assign sy_raw = {ring_rx_pin, ext_trig_n, all_units_ready_in, trig_n_in,
                   pen_hit_clear_in, pen_hit_n_in, pen_button_n, pen_light_pulse_n};

  // each lane resets to its pin's idle level, so no false edge or ready follows reset
  localparam logic [`CLPL_SY_N-1:0] SY_RST = `CLPL_SY_RST;

  genvar gi;
  generate
    for (gi = 0; gi < `CLPL_SY_N; gi++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sy_meta_reg[gi] <= SY_RST[gi];
          sy_reg[gi] <= SY_RST[gi];
          sy_prev_reg[gi] <= SY_RST[gi];
        end else begin
          sy_meta_reg[gi] <= sy_raw[gi];
          sy_reg[gi] <= sy_meta_reg[gi];
          sy_prev_reg[gi] <= sy_reg[gi];
        end
      end
    end
  endgenerate

  logic pulse_rise;
  logic btn_fall;
  logic trig_sel_n;
  logic trig_sel_prev_n;
  logic trig_fall;
  logic all_ready;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [`CLPL_CTRL_W-1:0] ctrl_reg;
  logic [`CLPL_EVT_W-1:0] evt_reg;
  logic pen_hit_latch_reg;
  logic loop_up_reg;
  clpl_role_t role;

  assign role = clpl_role_t'(ctrl_reg[`CLPL_CTRL_FOLLOW]);
  assign all_ready = sy_reg[`CLPL_SY_RDY];
  assign pulse_rise = sy_reg[`CLPL_SY_PULSE] & ~sy_prev_reg[`CLPL_SY_PULSE];
  assign btn_fall = ~sy_reg[`CLPL_SY_BTN] & sy_prev_reg[`CLPL_SY_BTN];
  // follower listens to the shared line, leader to its own bnc
  assign trig_sel_n = (role == CLPL_FOLLOWER) ? sy_reg[`CLPL_SY_TRIG] : sy_reg[`CLPL_SY_EXT];
  assign trig_sel_prev_n = (role == CLPL_FOLLOWER) ? sy_prev_reg[`CLPL_SY_TRIG]
                                                  : sy_prev_reg[`CLPL_SY_EXT];
  assign trig_fall = ~trig_sel_n & trig_sel_prev_n;

  // ------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ------------------------------------------------------------
  logic addr_ok;
  logic wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic [31:0] rd_word;
  logic wr_ctrl;
  logic wr_evt;

  assign addr_ok = hsel & hready & htrans[1];
  assign wr_ctrl = wr_pend_reg & (wr_addr_reg == `CLPL_CTRL_OFS);
  assign wr_evt = wr_pend_reg & (wr_addr_reg == `CLPL_EVT_OFS);

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (haddr[11:0])
      `CLPL_CTRL_OFS: rd_word[`CLPL_CTRL_W-1:0] = ctrl_reg;
      `CLPL_STAT_OFS: begin
        rd_word[`CLPL_STAT_HIT_N] = pen_hit_flag_n;
        rd_word[`CLPL_STAT_ALLRDY] = all_ready;
        rd_word[`CLPL_STAT_BTN_N] = sy_reg[`CLPL_SY_BTN];
        rd_word[`CLPL_STAT_LATCH] = pen_hit_latch_reg;
        rd_word[`CLPL_STAT_LOOPUP] = loop_up_reg;
      end
      `CLPL_EVT_OFS: rd_word[`CLPL_EVT_W-1:0] = evt_reg;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_reg <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr_reg <= (haddr[31:12] == 20'h0_0000) ? haddr[11:0] : 12'hFFF;
      end
      if (addr_ok && !hwrite) begin
        hrdata <= (haddr[31:12] == 20'h0_0000) ? rd_word : 32'h0000_0000;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `CLPL_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= hwdata[`CLPL_CTRL_W-1:0];
    end
  end

  // events: hardware set wins over a write-one clear in the same cycle
  logic [`CLPL_EVT_W-1:0] evt_set;
  assign evt_set = {trig_fall & (role == CLPL_FOLLOWER) & ~all_ready,
                    trig_fall & ~((role == CLPL_FOLLOWER) & ~all_ready),
                    btn_fall};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_reg <= `CLPL_EVT_RST;
    end else begin
      evt_reg <= (evt_reg & ~(wr_evt ? hwdata[`CLPL_EVT_W-1:0] : 3'h0)) | evt_set;
    end
  end

  // ------------------------------------------------------------
  // pen hit latch
  // ------------------------------------------------------------
  logic latch_clr;
  // own clear bit or any unit pulling the shared clear line
  assign latch_clr = ctrl_reg[`CLPL_CTRL_PCLR] | sy_reg[`CLPL_SY_CLR];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pen_hit_latch_reg <= 1'b0;
    end else if (pulse_rise) begin
      pen_hit_latch_reg <= 1'b1;
    end else if (latch_clr) begin
      pen_hit_latch_reg <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pen_hit_flag_n <= 1'b1;
    end else if (role == CLPL_FOLLOWER) begin
      pen_hit_flag_n <= sy_reg[`CLPL_SY_HIT];
    end else begin
      pen_hit_flag_n <= ~pen_hit_latch_reg;
    end
  end

  // ------------------------------------------------------------
  // shared open-collector lines
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pen_hit_n_out <= 1'b1;
      pen_hit_n_oe <= 1'b0;
      pen_hit_clear_out <= 1'b0;
      pen_hit_clear_oe <= 1'b0;
      trig_n_out <= 1'b1;
      trig_n_oe <= 1'b0;
      all_units_ready_out <= 1'b0;
      all_units_ready_oe <= 1'b1;
    end else begin
      // out is the level this unit asserts; oe is high only while it really pulls or drives the line
      pen_hit_n_out <= ~((role == CLPL_LEADER) & pen_hit_latch_reg);
      pen_hit_n_oe <= (role == CLPL_LEADER) & pen_hit_latch_reg;
      pen_hit_clear_out <= ctrl_reg[`CLPL_CTRL_PCLR];
      pen_hit_clear_oe <= ctrl_reg[`CLPL_CTRL_PCLR];
      trig_n_out <= ~((role == CLPL_LEADER) & ctrl_reg[`CLPL_CTRL_TRIG]);
      trig_n_oe <= (role == CLPL_LEADER) & ctrl_reg[`CLPL_CTRL_TRIG];
      all_units_ready_out <= ctrl_reg[`CLPL_CTRL_READY];
      all_units_ready_oe <= ~ctrl_reg[`CLPL_CTRL_READY];
    end
  end

  // ------------------------------------------------------------
  // serial ring with retransmission
  // ------------------------------------------------------------
  logic rts_on;
  assign rts_on = (role == CLPL_LEADER) | ctrl_reg[`CLPL_CTRL_ANSWER];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rts_n <= 1'b0;
      ring_tx_pin <= 1'b1;
      local_rx <= 1'b1;
    end else begin
      rts_n <= ~rts_on;
      // three cycles of latency per hop (two synchroniser flops and this register); negligible against any uart bit time
      ring_tx_pin <= sy_reg[`CLPL_SY_RX] | (local_tx & rts_on);
      local_rx <= sy_reg[`CLPL_SY_RX];
    end
  end

  // ------------------------------------------------------------
  // trigger, button and loop status
  // ------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pen_button_irq <= 1'b0;
      trigger_irq <= 1'b0;
      unit_reset_req <= 1'b0;
      refresh_en <= 1'b1;
      loop_up_reg <= 1'b0;
    end else begin
      pen_button_irq <= evt_set[`CLPL_EVT_BTN];
      trigger_irq <= evt_set[`CLPL_EVT_TRIG];
      unit_reset_req <= evt_set[`CLPL_EVT_RESET];
      refresh_en <= ~ctrl_reg[`CLPL_CTRL_SCAN];
      if (all_ready) begin
        loop_up_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_latch_sets: assert property (pulse_rise |=> pen_hit_latch_reg)
    else $error("hit latch did not set on light edge");
  chk_latch_clears: assert property (latch_clr && !pulse_rise |=> !pen_hit_latch_reg)
    else $error("hit latch did not clear");
  chk_leader_flag: assert property (role == CLPL_LEADER ##1 role == CLPL_LEADER
    |-> pen_hit_flag_n == !$past(pen_hit_latch_reg))
    else $error("leader hit flag does not follow latch");
  chk_follower_flag: assert property ($past(role) == CLPL_FOLLOWER
    |-> pen_hit_flag_n == $past(sy_reg[`CLPL_SY_HIT]))
    else $error("follower hit flag not from shared line");
  chk_button_irq: assert property (btn_fall |=> pen_button_irq ##1 !pen_button_irq)
    else $error("button interrupt not a single pulse");
  chk_follower_nodrive: assert property ($past(role) == CLPL_FOLLOWER |-> !trig_n_oe)
    else $error("follower drives shared trigger");
  chk_tx_gated: assert property (role == CLPL_FOLLOWER && !ctrl_reg[`CLPL_CTRL_ANSWER]
    && !sy_reg[`CLPL_SY_RX] |=> !ring_tx_pin)
    else $error("blocked local tx reached ring");
  chk_retransmit: assert property (sy_reg[`CLPL_SY_RX] |=> ring_tx_pin)
    else $error("received ring data not retransmitted");
  chk_leader_rts: assert property (role == CLPL_LEADER |=> !rts_n)
    else $error("leader request to send negated");
  chk_follow_reset: assert property (trig_fall && role == CLPL_FOLLOWER && !all_ready
    |=> unit_reset_req && !trigger_irq)
    else $error("follower did not reset on trigger without all ready");
  chk_ready_pull: assert property (!ctrl_reg[`CLPL_CTRL_READY] |=> all_units_ready_oe)
    else $error("unready unit does not pull all ready");

  // trigger source and request-to-send follow the role, refresh follows the scan bit
  chk_trig_leader: assert property (trig_fall && role == CLPL_LEADER
    |=> trigger_irq && !unit_reset_req)
    else $error("leader missed an external trigger");
  chk_follow_trig: assert property (trig_fall && role == CLPL_FOLLOWER && all_ready
    |=> trigger_irq && !unit_reset_req)
    else $error("follower did not trigger with all ready");
  chk_leader_no_reset: assert property (role == CLPL_LEADER |=> !unit_reset_req)
    else $error("leader asked for a unit reset");
  chk_follower_rts: assert property (role == CLPL_FOLLOWER && !ctrl_reg[`CLPL_CTRL_ANSWER]
    |=> rts_n)
    else $error("follower asserts request to send without answering");
  chk_refresh_off: assert property (ctrl_reg[`CLPL_CTRL_SCAN] |=> !refresh_en)
    else $error("refresh still running during scan");
  chk_loop_wait: assert property (!loop_up_reg && !all_ready |=> !loop_up_reg)
    else $error("loop marked up before all units ready");
  chk_ready_release: assert property (ctrl_reg[`CLPL_CTRL_READY]
    |=> !all_units_ready_oe && all_units_ready_out)
    else $error("ready unit still pulls all ready");
  chk_local_rx: assert property (local_rx == $past(sy_reg[`CLPL_SY_RX]))
    else $error("local receive does not follow ring");

  // shared lines pull only while this unit asserts them
  chk_hit_pull: assert property ($past(role) == CLPL_LEADER && $past(pen_hit_latch_reg)
    |-> pen_hit_n_oe && !pen_hit_n_out)
    else $error("leader does not pull the shared hit line");
  chk_clear_drive: assert property (pen_hit_clear_oe == $past(ctrl_reg[`CLPL_CTRL_PCLR]))
    else $error("shared clear drive does not follow clear bit");
  chk_trig_pull: assert property ($past(role) == CLPL_LEADER && $past(ctrl_reg[`CLPL_CTRL_TRIG])
    |-> trig_n_oe && !trig_n_out)
    else $error("leader does not pull the shared trigger");

  // event bits: a hardware set wins, a write of one clears otherwise
  chk_evt_btn_hold: assert property (evt_set[`CLPL_EVT_BTN] |=> evt_reg[`CLPL_EVT_BTN])
    else $error("button event lost");
  chk_evt_trig_hold: assert property (evt_set[`CLPL_EVT_TRIG] |=> evt_reg[`CLPL_EVT_TRIG])
    else $error("trigger event lost");
  chk_evt_rst_hold: assert property (evt_set[`CLPL_EVT_RESET] |=> evt_reg[`CLPL_EVT_RESET])
    else $error("reset event lost");
  chk_evt_clear: assert property (wr_evt && hwdata[`CLPL_EVT_BTN] && !evt_set[`CLPL_EVT_BTN]
    |=> !evt_reg[`CLPL_EVT_BTN])
    else $error("button event not cleared by write");

  cov_pen_hit: cover property (pulse_rise ##1 pen_hit_latch_reg ##[1:20] latch_clr);
  cov_follow_trig: cover property (trig_fall && role == CLPL_FOLLOWER && all_ready);
  cov_follow_reset: cover property (unit_reset_req);
  cov_button: cover property (pen_button_irq);
  cov_answer: cover property (role == CLPL_FOLLOWER && ctrl_reg[`CLPL_CTRL_ANSWER] ##1 !rts_n);

endmodule : clpl_top

/* design/clpl_defines.svh */
// constants for the chain link and pen latch block
`ifndef CLPL_DEFINES_SVH
`define CLPL_DEFINES_SVH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define CLPL_CTRL_OFS 12'h000
`define CLPL_STAT_OFS 12'h004
`define CLPL_EVT_OFS 12'h008

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define CLPL_CTRL_FOLLOW 0
`define CLPL_CTRL_ANSWER 1
`define CLPL_CTRL_PCLR 2
`define CLPL_CTRL_TRIG 3
`define CLPL_CTRL_READY 4
`define CLPL_CTRL_SCAN 5
`define CLPL_CTRL_W 6
`define CLPL_CTRL_RST 6'h00

// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define CLPL_STAT_HIT_N 0
`define CLPL_STAT_ALLRDY 1
`define CLPL_STAT_BTN_N 2
`define CLPL_STAT_LATCH 3
`define CLPL_STAT_LOOPUP 4

// ------------------------------------------------------------
// event fields, write one to clear
// ------------------------------------------------------------
`define CLPL_EVT_BTN 0
`define CLPL_EVT_TRIG 1
`define CLPL_EVT_RESET 2
`define CLPL_EVT_W 3
`define CLPL_EVT_RST 3'h0

// ------------------------------------------------------------
// synchroniser lanes
// ------------------------------------------------------------
`define CLPL_SY_PULSE 0
`define CLPL_SY_BTN 1
`define CLPL_SY_HIT 2
`define CLPL_SY_CLR 3
`define CLPL_SY_TRIG 4
`define CLPL_SY_RDY 5
`define CLPL_SY_EXT 6
`define CLPL_SY_RX 7
`define CLPL_SY_N 8
// clear and all-ready lanes start low, so reset shows neither a stray clear nor a false ready
`define CLPL_SY_RST 8'hD7

`endif

/* design/clpl_pkg.sv */
// types shared by the chain link and pen latch block
package clpl_pkg;
  typedef logic [31:0] clpl_word_t;
  typedef enum logic [0:0] {
    CLPL_LEADER = 1'b0,
    CLPL_FOLLOWER = 1'b1
  } clpl_role_t;
endpackage : clpl_pkg

/* verification/clpl_far_side.sv */
// far side model: one neighbouring unit on the shared lines and ring, plus the light pen
`timescale 1ns/1ps

module clpl_far_side #(
  parameter int PULSE_CYC = 750 // pen pulse, 15 us at 50 MHz
) (
  input wire logic hclk, // bench clock, times every change
  input wire logic pen_hit_n_oe, // dut pulls hit line
  input wire logic pen_hit_n_out, // dut hit drive value
  input wire logic pen_hit_clear_oe, // dut drives clear line
  input wire logic pen_hit_clear_out, // dut clear drive value
  input wire logic trig_n_oe, // dut pulls trigger line
  input wire logic trig_n_out, // dut trigger drive value
  input wire logic all_units_ready_oe, // dut pulls all-ready line
  input wire logic all_units_ready_out, // dut all-ready drive value
  output logic pen_hit_n_in, // resolved hit line
  output logic pen_hit_clear_in, // resolved clear line
  output logic trig_n_in, // resolved trigger line
  output logic all_units_ready_in, // resolved all-ready line
  output logic pen_light_pulse_n, // pen light pulse
  output logic pen_button_n, // pen button level
  output logic ring_rx_pin // ring data from the far unit
);
  logic far_hit = 1'b0;
  logic far_clr = 1'b0;
  logic far_trig = 1'b0;
  logic far_up = 1'b1;
  logic far_rx = 1'b1;

  initial begin
    pen_light_pulse_n = 1'b1;
    pen_button_n = 1'b1;
  end

  // ------------------------------------------------------------
  // shared lines
  // ------------------------------------------------------------
  // released lines sit at the pull level; only an active pull moves them
  assign pen_hit_n_in = ~((pen_hit_n_oe & ~pen_hit_n_out) | far_hit);
  assign pen_hit_clear_in = (pen_hit_clear_oe & pen_hit_clear_out) | far_clr;
  assign trig_n_in = ~((trig_n_oe & ~trig_n_out) | far_trig);
  // a far unit that is down or busy holds the line low
  assign all_units_ready_in = ~((all_units_ready_oe & ~all_units_ready_out) | ~far_up);
  assign ring_rx_pin = far_rx;

  // ------------------------------------------------------------
  // stimulus tasks
  // ------------------------------------------------------------
  task flash();
    @(posedge hclk);
    pen_light_pulse_n <= 1'b0;
    repeat (PULSE_CYC) @(posedge hclk);
    pen_light_pulse_n <= 1'b1;
  endtask : flash

  task button(input logic down);
    @(posedge hclk);
    pen_button_n <= ~down;
  endtask : button

  // bits: hit pull, clear drive, trigger pull, unit up and ready, ring level
  task set_far(input logic [4:0] v);
    @(posedge hclk);
    {far_hit, far_clr, far_trig, far_up, far_rx} <= v;
  endtask : set_far
endmodule : clpl_far_side

/* verification/tb_top.sv */
// self-checking bench for the chain link and pen latch block
`timescale 1ns/1ps
`include "clpl_defines.svh"

module tb_top;
  import clpl_pkg::*;
  localparam logic [31:0] FOL = 32'h0000_0001 << `CLPL_CTRL_FOLLOW;
  localparam logic [31:0] ANS = 32'h0000_0001 << `CLPL_CTRL_ANSWER;
  localparam logic [31:0] CLR = 32'h0000_0001 << `CLPL_CTRL_PCLR;
  localparam logic [31:0] TRG = 32'h0000_0001 << `CLPL_CTRL_TRIG;
  localparam logic [31:0] RDY = 32'h0000_0001 << `CLPL_CTRL_READY;
  localparam logic [31:0] SCN = 32'h0000_0001 << `CLPL_CTRL_SCAN;
  localparam logic [31:0] CTRL = {20'h0_0000, `CLPL_CTRL_OFS};
  localparam logic [31:0] STAT = {20'h0_0000, `CLPL_STAT_OFS};
  localparam logic [31:0] EVT = {20'h0_0000, `CLPL_EVT_OFS};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0, ext_trig_n = 1'b1, local_tx = 1'b1;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, ring_tx_pin, ring_rx_pin, local_rx, rts_n, pen_light_pulse_n, pen_button_n;
  logic pen_hit_n_in, pen_hit_n_out, pen_hit_n_oe, pen_hit_clear_in, pen_hit_clear_out, pen_hit_clear_oe;
  logic trig_n_in, trig_n_out, trig_n_oe, all_units_ready_in, all_units_ready_out, all_units_ready_oe;
  logic pen_hit_flag_n, pen_button_irq, trigger_irq, unit_reset_req, refresh_en;
  int mismatches = 0, check_count = 0, cycles = 0, n_btn = 0, n_trg = 0, n_rst = 0, b, c;

  clpl_top u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hrdata, .hresp, .pen_light_pulse_n, .pen_button_n, .ext_trig_n, .ring_rx_pin, .ring_tx_pin,
    .local_tx, .local_rx, .rts_n, .pen_hit_n_in, .pen_hit_n_out, .pen_hit_n_oe, .pen_hit_clear_in,
    .pen_hit_clear_out, .pen_hit_clear_oe, .trig_n_in, .trig_n_out, .trig_n_oe, .all_units_ready_in,
    .all_units_ready_out, .all_units_ready_oe, .pen_hit_flag_n, .pen_button_irq, .trigger_irq,
    .unit_reset_req, .refresh_en);

  clpl_far_side u_far (.hclk, .pen_hit_n_oe, .pen_hit_n_out, .pen_hit_clear_oe, .pen_hit_clear_out, .trig_n_oe,
    .trig_n_out, .all_units_ready_oe, .all_units_ready_out, .pen_hit_n_in, .pen_hit_clear_in, .trig_n_in,
    .all_units_ready_in, .pen_light_pulse_n, .pen_button_n, .ring_rx_pin);

  always #10 hclk = ~hclk;

  // ------------------------------------------------------------
  // pulse counters and timeout
  // ------------------------------------------------------------
  // one-cycle pulses are counted on the falling edge, where they are settled
  always @(negedge hclk) begin
    cycles++;
    if (pen_button_irq === 1'b1) n_btn++;
    if (trigger_irq === 1'b1) n_trg++;
    if (unit_reset_req === 1'b1) n_rst++;
    if (cycles == 20000) begin
      mismatches++;
      $display("BAD t=%0t timeout", $time);
      give_verdict();
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task give_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask : check

  task chk(input logic seen, input logic exp);
    check({31'h0000_0000, seen}, {31'h0000_0000, exp});
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  // one single ahb-lite transfer; read data lands in rd
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    hsel <= 1'b0;
  endtask : ahb

  task wr(input logic [31:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask : wr

  task rdm(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000);
    check(rd & m, exp);
  endtask : rdm

  task ext_pulse();
    @(posedge hclk);
    ext_trig_n <= 1'b0;
    tick(4);
    ext_trig_n <= 1'b1;
  endtask : ext_pulse

  task ring(input logic rx, input logic ltx, input logic exp);
    u_far.set_far({4'h1, rx});
    local_tx <= ltx;
    tick(5);
    chk(local_rx, rx);
    chk(ring_tx_pin, exp);
  endtask : ring

  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    tick(1);
    chk(rts_n, 1'h0);
    chk(pen_hit_flag_n, 1'h1);
    chk(all_units_ready_oe, 1'h1);
    rdm(CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
    rdm(STAT, 32'h0000_0012, 32'h0000_0000);
    $display("reset test done");
    wr(CTRL, RDY | SCN);
    tick(2);
    chk(refresh_en, 1'h0);
    chk(all_units_ready_oe, 1'h0);
    wr(32'h0000_1000, 32'hFFFF_FFFF);
    rdm(32'h0000_1000, 32'hFFFF_FFFF, 32'h0000_0000);
    tick(4);
    rdm(STAT, 32'h0000_0012, 32'h0000_0012);
    u_far.set_far(5'h01);
    tick(5);
    rdm(STAT, 32'h0000_0012, 32'h0000_0010);
    u_far.set_far(5'h03);
    $display("ready test done");
    fork
      u_far.flash();
      begin
        tick(20);
        chk(pen_hit_flag_n, 1'h1);
      end
    join
    tick(6);
    chk(pen_hit_flag_n, 1'h0);
    chk(pen_hit_n_oe, 1'h1);
    rdm(STAT, 32'h0000_0009, 32'h0000_0008);
    wr(CTRL, RDY | CLR);
    tick(2);
    chk(pen_hit_clear_oe, 1'h1);
    tick(4);
    chk(pen_hit_flag_n, 1'h1);
    chk(pen_hit_n_oe, 1'h0);
    wr(CTRL, RDY);
    u_far.flash();
    u_far.set_far(5'h0B);
    tick(6);
    chk(pen_hit_flag_n, 1'h1);
    u_far.set_far(5'h03);
    b = n_btn;
    u_far.button(1'b1);
    tick(6);
    check(32'(n_btn - b), 32'h0000_0001);
    u_far.button(1'b0);
    tick(6);
    check(32'(n_btn - b), 32'h0000_0001);
    rdm(EVT, 32'h0000_0001, 32'h0000_0001);
    wr(EVT, 32'h0000_0001);
    rdm(EVT, 32'h0000_0001, 32'h0000_0000);
    $display("pen test done");
    wr(CTRL, RDY | TRG);
    tick(2);
    chk(trig_n_oe, 1'h1);
    b = n_trg;
    ext_pulse();
    tick(5);
    check(32'(n_trg - b), 32'h0000_0001);
    wr(CTRL, FOL | RDY | TRG);
    tick(2);
    chk(trig_n_oe, 1'h0);
    chk(rts_n, 1'h1);
    b = n_trg;
    ext_pulse();
    tick(5);
    u_far.set_far(5'h07);
    tick(6);
    check(32'(n_trg - b), 32'h0000_0001);
    u_far.set_far(5'h13);
    tick(6);
    chk(pen_hit_flag_n, 1'h0);
    c = n_rst;
    u_far.set_far(5'h01);
    tick(5);
    u_far.set_far(5'h05);
    tick(6);
    check(32'(n_rst - c), 32'h0000_0001);
    check(32'(n_trg - b), 32'h0000_0001);
    $display("trigger test done");
    ring(1'b0, 1'b1, 1'b0);
    ring(1'b1, 1'b0, 1'b1);
    wr(CTRL, FOL | ANS | RDY);
    tick(2);
    chk(rts_n, 1'h0);
    ring(1'b0, 1'b1, 1'b1);
    wr(CTRL, RDY);
    ring(1'b0, 1'b0, 1'b0);
    ring(1'b0, 1'b1, 1'b1);
    $display("ring test done");
    give_verdict();
  end
endmodule : tb_top
